// File: bfs_pkg.sv
// Constants, register map and encodings for the breaker failure supervisor.
// Assumes a single 250 MHz clock and a classic Wishbone register port.
// Summary of operation
// - Current scheme: trip if current stays high
// - Position scheme: trip if not shown open
// - Combined: trip if current high and not open
// - Timer keeps running after trigger drops
// - Timer expiry asserts backup trip output
// - Opening per scheme stops the timer
// - Open with trigger active enters rejected state
// - Rejected returns to standby when triggers drop
// - Lock rises with trip, latched until cleared
// - Start from trigger class or three extras
package bfs_pkg;

  // ---------------------------------------------------------------
  // Widths and timing
  // ---------------------------------------------------------------
  localparam int CUR_W        = 16;
  localparam int TIME_W       = 16;
  localparam int CLOCK_MHZ    = 250;
  localparam int TICK_US      = 1000;
  localparam int TICK_CYCLES  = CLOCK_MHZ * TICK_US;
  localparam int TICK_CNT_W   = 18;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] TIME_OFS   = 8'h04;
  localparam logic [7:0] THR_OFS    = 8'h08;
  localparam logic [7:0] STAT_OFS   = 8'h0c;
  localparam logic [7:0] IRQ_OFS    = 8'h10;
  localparam logic [7:0] IEN_OFS    = 8'h14;
  localparam logic [7:0] ICLR_OFS   = 8'h18;
  localparam logic [7:0] ACK_OFS    = 8'h1c;

  // ---------------------------------------------------------------
  // Control fields and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_SCHEME_LSB = 0;
  localparam int CTRL_CLASS_LSB  = 2;
  localparam int CTRL_EXTRA_LSB  = 4;
  localparam logic [1:0]        SCHEME_RST = 2'h0;
  localparam logic [1:0]        CLASS_RST  = 2'h0;
  localparam logic [2:0]        EXTRA_RST  = 3'h0;
  localparam logic [TIME_W-1:0] TIME_RST   = 16'h0064;
  localparam logic [CUR_W-1:0]  THR_RST    = 16'h0100;

  // Interrupt bits
  localparam int IRQ_TRIP   = 0;
  localparam int IRQ_REJECT = 1;
  localparam int IRQ_START  = 2;
  localparam int IRQ_W      = 3;

  typedef enum logic [1:0] {
    CURRENT_CHECK_SCHEME  = 2'h0,
    POSITION_CHECK_SCHEME = 2'h1,
    COMBINED_CHECK_SCHEME = 2'h2
  } scheme_type;

  typedef enum logic [1:0] {
    CLASS_ALL      = 2'h0,
    CLASS_EXTERNAL = 2'h1,
    CLASS_CURRENT  = 2'h2,
    CLASS_NONE     = 2'h3
  } trigger_class_type;

  // Gray order along standby -> running -> tripped; rejected off running
  typedef enum logic [1:0] {
    ST_STANDBY  = 2'b00,
    ST_RUNNING  = 2'b01,
    ST_TRIPPED  = 2'b11,
    ST_REJECTED = 2'b10
  } state_type;

endpackage

// File: tick_divider.sv
// One-cycle tick enable every TICK_CYCLES clocks.
// Assumes the shared clock and synchronous active-low reset.
`timescale 1ns/1ns
module tick_divider #(
  parameter int TICK_CYCLES = bfs_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic nrst_i,
  // Tick
  input  wire logic clear_i,
  output logic      tick_o
);

  localparam logic [bfs_pkg::TICK_CNT_W-1:0] LAST =
    bfs_pkg::TICK_CNT_W'(TICK_CYCLES - 1);

  logic [bfs_pkg::TICK_CNT_W-1:0] cnt_q;

  // Clear realigns the tick phase to the start of supervision
  always_ff @(posedge clock_i) begin
    if (!nrst_i || clear_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q  <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 1'b1;
      tick_o <= 1'b0;
    end
  end

endmodule // tick_divider

// File: breaker_failure_supervisor.sv
// Breaker failure supervisor with Wishbone register port and interrupt.
// Assumes trip, position and current inputs come from outside the clock domain.
`timescale 1ns/1ns
module breaker_failure_supervisor #(
  parameter int TICK_CYCLES = bfs_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                     clock_i,
  input  wire logic                     nrst_i,
  // Wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // Trip sources
  input  wire logic                     ext_trip_i,
  input  wire logic                     cur_trip_i,
  input  wire logic                     other_trip_i,
  input  wire logic [2:0]               extra_trigger_input_i,
  // Breaker measurement and position
  input  wire logic [bfs_pkg::CUR_W-1:0] phase_a_current_i,
  input  wire logic [bfs_pkg::CUR_W-1:0] phase_b_current_i,
  input  wire logic [bfs_pkg::CUR_W-1:0] phase_c_current_i,
  input  wire logic                     pos_open_i,
  input  wire logic                     pos_closed_i,
  // Outputs
  output logic                          backup_trip_o,
  output logic                          lock_o,
  output logic                          irq_o
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  localparam int SYNC_W = 8 + 3 * bfs_pkg::CUR_W;

  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;

  // Multi-bit currents may be caught mid-change for one cycle; the
  // running state acts on a single low reading, so such a glitch ends supervision.
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {ext_trip_i, cur_trip_i, other_trip_i, extra_trigger_input_i,
                  pos_open_i, pos_closed_i,
                  phase_a_current_i, phase_b_current_i, phase_c_current_i};
      sync2_q <= sync1_q;
    end
  end

  logic                      ext_s;
  logic                      cur_s;
  logic                      oth_s;
  logic [2:0]                extra_s;
  logic                      open_s;
  logic                      closed_s;
  logic [bfs_pkg::CUR_W-1:0] ia_s;
  logic [bfs_pkg::CUR_W-1:0] ib_s;
  logic [bfs_pkg::CUR_W-1:0] ic_s;

  assign {ext_s, cur_s, oth_s, extra_s, open_s, closed_s, ia_s, ib_s, ic_s} = sync2_q;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [1:0]                  scheme_q;
  logic [1:0]                  class_q;
  logic [2:0]                  extra_en_q;
  logic [bfs_pkg::TIME_W-1:0]  time_q;
  logic [bfs_pkg::CUR_W-1:0]   thr_q;
  logic [bfs_pkg::IRQ_W-1:0]   irq_stat_q;
  logic [bfs_pkg::IRQ_W-1:0]   irq_en_q;

  logic bus_req;
  logic wr_hit;
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_hit  = bus_req && wb_we_i;

  function automatic logic wr_at(input logic [7:0] ofs);
    wr_at = wr_hit && (wb_adr_i == ofs) && wb_sel_i[0];
  endfunction

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      scheme_q   <= bfs_pkg::SCHEME_RST;
      class_q    <= bfs_pkg::CLASS_RST;
      extra_en_q <= bfs_pkg::EXTRA_RST;
    end else if (wr_at(bfs_pkg::CTRL_OFS)) begin
      scheme_q   <= wb_dat_i[bfs_pkg::CTRL_SCHEME_LSB +: 2];
      class_q    <= wb_dat_i[bfs_pkg::CTRL_CLASS_LSB +: 2];
      extra_en_q <= wb_dat_i[bfs_pkg::CTRL_EXTRA_LSB +: 3];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      time_q <= bfs_pkg::TIME_RST;
    end else if (wr_hit && wb_adr_i == bfs_pkg::TIME_OFS) begin
      if (wb_sel_i[0]) time_q[7:0]  <= wb_dat_i[7:0];
      if (wb_sel_i[1]) time_q[15:8] <= wb_dat_i[15:8];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      thr_q <= bfs_pkg::THR_RST;
    end else if (wr_hit && wb_adr_i == bfs_pkg::THR_OFS) begin
      if (wb_sel_i[0]) thr_q[7:0]  <= wb_dat_i[7:0];
      if (wb_sel_i[1]) thr_q[15:8] <= wb_dat_i[15:8];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      irq_en_q <= '0;
    end else if (wr_at(bfs_pkg::IEN_OFS)) begin
      irq_en_q <= wb_dat_i[bfs_pkg::IRQ_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Trigger and opening detection
  // ---------------------------------------------------------------
  logic class_trig;
  logic trig_any;
  logic cur_low;
  logic opened;

  always_comb begin
    unique case (bfs_pkg::trigger_class_type'(class_q))
      bfs_pkg::CLASS_ALL:      class_trig = ext_s || cur_s || oth_s;
      bfs_pkg::CLASS_EXTERNAL: class_trig = ext_s;
      bfs_pkg::CLASS_CURRENT:  class_trig = cur_s;
      bfs_pkg::CLASS_NONE:     class_trig = 1'b0;
    endcase
  end

  assign trig_any = class_trig || |(extra_s & extra_en_q);

  // One comparator per phase; a single loaded pole keeps the breaker live
  logic [2:0]                phase_low;
  logic [bfs_pkg::CUR_W-1:0] phase_cur [3];

  assign phase_cur[0] = ia_s;
  assign phase_cur[1] = ib_s;
  assign phase_cur[2] = ic_s;

  for (genvar g = 0; g < 3; g++) begin : g_phase
    assign phase_low[g] = phase_cur[g] < thr_q;
  end

  assign cur_low = &phase_low;

  // Unused scheme code 3 falls back to the stricter combined check
  always_comb begin
    unique case (scheme_q)
      2'h0:    opened = cur_low;
      2'h1:    opened = open_s && !closed_s;
      default: opened = cur_low || (open_s && !closed_s);
    endcase
  end

  // ---------------------------------------------------------------
  // Supervision state machine
  // ---------------------------------------------------------------
  bfs_pkg::state_type          state_q;
  logic [bfs_pkg::TIME_W-1:0]  elapsed_q;
  logic                        tick;
  logic                        expire;
  logic                        ack_lock;

  tick_divider #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .clear_i (state_q != bfs_pkg::ST_RUNNING),
    .tick_o  (tick)
  );

  assign expire = tick && (elapsed_q + 1'b1 >= time_q);

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      state_q <= bfs_pkg::ST_STANDBY;
    end else begin
      unique case (state_q)
        bfs_pkg::ST_STANDBY: begin
          if (trig_any) state_q <= bfs_pkg::ST_RUNNING;
        end
        bfs_pkg::ST_RUNNING: begin
          // Trigger drop does not stop the timer
          if (opened) begin
            state_q <= trig_any ? bfs_pkg::ST_REJECTED : bfs_pkg::ST_STANDBY;
          end else if (expire) begin
            state_q <= bfs_pkg::ST_TRIPPED;
          end
        end
        bfs_pkg::ST_TRIPPED: begin
          if (!trig_any && opened) state_q <= bfs_pkg::ST_STANDBY;
        end
        bfs_pkg::ST_REJECTED: begin
          if (!trig_any) state_q <= bfs_pkg::ST_STANDBY;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i || state_q != bfs_pkg::ST_RUNNING) begin
      elapsed_q <= '0;
    end else if (tick) begin
      elapsed_q <= elapsed_q + 1'b1;
    end
  end

  logic trip_now;
  assign trip_now = state_q == bfs_pkg::ST_RUNNING && !opened && expire;

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      backup_trip_o <= 1'b0;
    end else begin
      backup_trip_o <= trip_now || (state_q == bfs_pkg::ST_TRIPPED &&
                       !(!trig_any && opened));
    end
  end

  // Lock is set with the trip and freed only by operator acknowledge
  assign ack_lock = wr_at(bfs_pkg::ACK_OFS) && wb_dat_i[0];

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      lock_o <= 1'b0;
    end else if (trip_now) begin
      lock_o <= 1'b1;
    end else if (ack_lock) begin
      lock_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  logic [bfs_pkg::IRQ_W-1:0] irq_evt;
  logic [bfs_pkg::IRQ_W-1:0] irq_clr;
  logic [bfs_pkg::IRQ_W-1:0] irq_stat_d;
  logic [bfs_pkg::IRQ_W-1:0] irq_en_d;

  assign irq_evt[bfs_pkg::IRQ_TRIP]   = trip_now;
  assign irq_evt[bfs_pkg::IRQ_REJECT] = state_q == bfs_pkg::ST_RUNNING && opened && trig_any;
  assign irq_evt[bfs_pkg::IRQ_START]  = state_q == bfs_pkg::ST_STANDBY && trig_any;
  assign irq_clr = wr_at(bfs_pkg::ICLR_OFS) ? wb_dat_i[bfs_pkg::IRQ_W-1:0] : '0;
  assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_evt;
  // Mask as it stands after this edge, so irq follows status and mask alike
  assign irq_en_d = wr_at(bfs_pkg::IEN_OFS) ? wb_dat_i[bfs_pkg::IRQ_W-1:0] : irq_en_q;

  // Set wins over a clear in the same cycle
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_d & irq_en_d);
    end
  end

  // ---------------------------------------------------------------
  // Bus read and acknowledge
  // ---------------------------------------------------------------
  logic [31:0] rd_data;

  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (wb_adr_i)
      bfs_pkg::CTRL_OFS: rd_data[6:0] = {extra_en_q, class_q, scheme_q};
      bfs_pkg::TIME_OFS: rd_data[15:0] = time_q;
      bfs_pkg::THR_OFS:  rd_data[15:0] = thr_q;
      bfs_pkg::STAT_OFS: rd_data[5:0] = {cur_low, trig_any, lock_o, backup_trip_o,
                                         state_q};
      bfs_pkg::IRQ_OFS:  rd_data[bfs_pkg::IRQ_W-1:0] = irq_stat_q;
      bfs_pkg::IEN_OFS:  rd_data[bfs_pkg::IRQ_W-1:0] = irq_en_q;
      default:           rd_data = 32'h0000_0000;
    endcase
  end

  // Unmapped addresses still ack with zero data so the master never hangs
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= (bus_req && !wb_we_i) ? rd_data : 32'h0000_0000;
    end
  end

endmodule // breaker_failure_supervisor

// File: bfs_asserts.sv
// Port checker for the breaker failure supervisor.
// Assumes a classic Wishbone master that holds each request until ack.
`timescale 1ns/1ns
module bfs_asserts #(
  parameter int TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        nrst_i,
  // Wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Outputs
  input wire logic        backup_trip_o,
  input wire logic        lock_o,
  input wire logic        irq_o
);
  logic req;
  logic ack_wr;
  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign ack_wr = req && wb_we_i && wb_adr_i == bfs_pkg::ACK_OFS && wb_sel_i[0] && wb_dat_i[0];

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  property p_rst_quiet;
    $rose(nrst_i) |-> !backup_trip_o && !lock_o && !irq_o && !wb_ack_o;
  endproperty
  property p_ack_next;  req |=> wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_dat_idle;  !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  property p_unmapped;  req && !wb_we_i && wb_adr_i == 8'h20 |=> wb_dat_o == 32'h0; endproperty
  property p_lock_trip; $rose(backup_trip_o) |-> lock_o; endproperty
  property p_lock_why;  $rose(lock_o) |-> $rose(backup_trip_o); endproperty
  property p_lock_hold; lock_o && !ack_wr |=> lock_o; endproperty
  property p_lock_clr;  ack_wr && lock_o |=> !lock_o || $rose(backup_trip_o); endproperty
  property p_irq_fall;  $fell(irq_o) |-> $past(wb_cyc_i && wb_we_i); endproperty

  a_rst_quiet: assert property (p_rst_quiet) else $error("output high after reset");
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_lock_trip: assert property (p_lock_trip) else $error("lock missing with trip");
  a_lock_why: assert property (p_lock_why) else $error("lock without trip");
  a_lock_hold: assert property (p_lock_hold) else $error("lock dropped");
  a_lock_clr: assert property (p_lock_clr) else $error("lock not cleared");
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");

  c_trip: cover property ($rose(backup_trip_o));
  c_clr: cover property (ack_wr && lock_o);
  c_irq: cover property ($rose(irq_o));
endmodule // bfs_asserts

bind breaker_failure_supervisor bfs_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clock_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .backup_trip_o, .lock_o, .irq_o
);

// File: breaker_model.sv
// Supervised breaker: opens on command after a delay, can stick.
// Assumes the bench commands opening whenever the relay trips.
`timescale 1ns/1ns
module breaker_model #(
  parameter logic [15:0] LOAD  = 16'h0400,
  parameter int          DELAY = 3
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  // Command and faults
  input  wire logic        open_cmd_i,
  input  wire logic        lock_i,
  input  wire logic        stuck_cur_i,
  input  wire logic        stuck_pos_i,
  // Measurement
  output logic      [15:0] cur_a_o,
  output logic      [15:0] cur_b_o,
  output logic      [15:0] cur_c_o,
  output logic             pos_open_o,
  output logic             pos_closed_o
);
  int   cnt_q;
  logic open_q;
  // Short opening delay keeps the chain well inside the supervision time
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      cnt_q  <= 0;
      open_q <= 1'b0;
    end else if (open_cmd_i) begin
      if (cnt_q == DELAY) open_q <= 1'b1;
      else cnt_q <= cnt_q + 1;
    end else if (!lock_i) begin
      cnt_q  <= 0;
      open_q <= 1'b0;
    end
  end
  assign cur_a_o = open_q ? 16'h0 : LOAD;
  assign cur_b_o = open_q ? 16'h0 : LOAD;
  // A stuck pole keeps one phase loaded alone
  assign cur_c_o = (open_q && !stuck_cur_i) ? 16'h0 : LOAD;
  assign pos_open_o   = open_q && !stuck_pos_i;
  assign pos_closed_o = !pos_open_o;
endmodule // breaker_model

// File: breaker_failure_supervisor_tb.sv
// Self-checking bench for the breaker failure supervisor.
// Assumes a 4-cycle tick and the breaker model on the measurement side.
`timescale 1ns/1ns
module breaker_failure_supervisor_tb;
  localparam int K = 4;
  localparam int T = 10;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, backup_trip_o, lock_o, irq_o;
  logic ext_trip_i = 1'b0, cur_trip_i = 1'b0, other_trip_i = 1'b0;
  logic [2:0] extra_trigger_input_i = 3'h0;
  logic [15:0] phase_a_current_i, phase_b_current_i, phase_c_current_i;
  logic pos_open_i, pos_closed_i;
  logic open_cmd = 1'b0, stuck_cur = 1'b0, stuck_pos = 1'b0;
  logic [3:0] sel_n = 4'hf;
  int err_count = 0;
  int checks_done = 0;

  always #2 clock_i = ~clock_i;

  breaker_failure_supervisor #(.TICK_CYCLES(K)) uut (
    .clock_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_trip_i, .cur_trip_i, .other_trip_i,
    .extra_trigger_input_i, .phase_a_current_i, .phase_b_current_i,
    .phase_c_current_i, .pos_open_i, .pos_closed_i, .backup_trip_o, .lock_o, .irq_o
  );
  breaker_model brk (
    .clock_i, .nrst_i, .open_cmd_i(open_cmd), .lock_i(lock_o), .stuck_cur_i(stuck_cur),
    .stuck_pos_i(stuck_pos), .cur_a_o(phase_a_current_i), .cur_b_o(phase_b_current_i),
    .cur_c_o(phase_c_current_i), .pos_open_o(pos_open_i), .pos_closed_o(pos_closed_i)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sel_n;
    // Only the watchdog bounds this wait
    do begin
      @(posedge clock_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk(n, 32'h2, "bus ack latency");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q & mk, e, "register read");
  endtask
  task automatic wt(input logic lvl, input int lim);
    int n;
    n = 0;
    while (backup_trip_o !== lvl && n < lim) begin
      @(posedge clock_i);
      n++;
    end
    chk({31'h0, backup_trip_o}, {31'h0, lvl}, "trip level");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rd(bfs_pkg::CTRL_OFS, 32'h7f, 32'h0);
    rd(bfs_pkg::TIME_OFS, 32'hffff, 32'h64);
    rd(bfs_pkg::THR_OFS, 32'hffff, 32'h100);
    sel_n = 4'h1;
    wr(bfs_pkg::THR_OFS, 32'h0000_5a5a);
    rd(bfs_pkg::THR_OFS, 32'hffff, 32'h015a);
    sel_n = 4'hf;
    wr(bfs_pkg::THR_OFS, 32'h100);
    rd(8'h20, 32'hffffffff, 32'h0);
    wr(8'h20, 32'hffffffff);
    rd(8'h20, 32'hffffffff, 32'h0);
    wr(bfs_pkg::TIME_OFS, T);
    rd(bfs_pkg::TIME_OFS, 32'hffff, T);
    wr(bfs_pkg::IEN_OFS, 32'h1);
    rd(bfs_pkg::IEN_OFS, 32'h7, 32'h1);
    $display("test regs done");
  endtask
  // Breaker looks open to the check the scheme does not use, or to no check at all; the scheme must still trip
  task automatic t_fail(input logic [1:0] s, input logic c, input logic p);
    wr(bfs_pkg::CTRL_OFS, {30'h0, s});
    stuck_cur <= c;
    stuck_pos <= p;
    ext_trip_i <= 1'b1;
    open_cmd <= 1'b1;
    repeat (4) @(posedge clock_i);
    ext_trip_i <= 1'b0;
    repeat (T * K - 3) @(posedge clock_i);
    chk(backup_trip_o, 1'b0, "early trip");
    wt(1'b1, 12);
    repeat (2) @(posedge clock_i);
    chk(lock_o, 1'b1, "lock");
    chk(irq_o, 1'b1, "irq set");
    rd(bfs_pkg::STAT_OFS, 32'h3f, {26'h0, !c, 5'h0f});
    wr(bfs_pkg::ICLR_OFS, 32'h1);
    repeat (3) @(posedge clock_i);
    chk(irq_o, 1'b0, "irq clear");
    rd(bfs_pkg::IRQ_OFS, 32'h7, 32'h4);
    chk(lock_o, 1'b1, "lock held");
    wr(bfs_pkg::ACK_OFS, 32'h1);
    @(posedge clock_i);
    chk(lock_o, 1'b0, "lock ack");
    chk(backup_trip_o, 1'b1, "trip stands");
    stuck_cur <= 1'b0;
    stuck_pos <= 1'b0;
    wt(1'b0, 20);
    open_cmd <= 1'b0;
    repeat (10) @(posedge clock_i);
    $display("test fail %0d done", s);
  endtask
  // Breaker opens as the scheme sees it while the trigger stays high
  task automatic t_rej(input logic [1:0] s, input logic c, input logic p);
    wr(bfs_pkg::CTRL_OFS, {30'h0, s});
    stuck_cur <= c;
    stuck_pos <= p;
    ext_trip_i <= 1'b1;
    open_cmd <= 1'b1;
    repeat (T * K + 20) @(posedge clock_i);
    chk(backup_trip_o, 1'b0, "trip after opening");
    rd(bfs_pkg::STAT_OFS, 32'h3, 32'h2);
    rd(bfs_pkg::IRQ_OFS, 32'h2, 32'h2);
    ext_trip_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    rd(bfs_pkg::STAT_OFS, 32'h3, 32'h0);
    open_cmd <= 1'b0;
    stuck_cur <= 1'b0;
    stuck_pos <= 1'b0;
    repeat (10) @(posedge clock_i);
    $display("test reject %0d done", s);
  endtask
  // Sources: ext, current, other, extra input 0 (always enabled here)
  task automatic t_trig;
    logic [3:0] tab [4] = '{4'hf, 4'h9, 4'ha, 4'h8};
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 4; j++) begin
        wr(bfs_pkg::CTRL_OFS, {25'h0, 3'h1, i[1:0], 2'h0});
        {other_trip_i, cur_trip_i, ext_trip_i} <= 3'(1 << j);
        extra_trigger_input_i <= {2'h0, j == 3};
        repeat (8) @(posedge clock_i);
        rd(bfs_pkg::STAT_OFS, 32'h3, {31'h0, tab[i][j]});
        {other_trip_i, cur_trip_i, ext_trip_i} <= 3'h0;
        extra_trigger_input_i <= 3'h0;
        open_cmd <= 1'b1;
        repeat (12) @(posedge clock_i);
        rd(bfs_pkg::STAT_OFS, 32'h3, 32'h0);
        open_cmd <= 1'b0;
        repeat (8) @(posedge clock_i);
      end
    end
    $display("test triggers done");
  endtask

  task automatic results;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock_i);
    err_count++;
    results();
  end

  initial begin
    repeat (20) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_regs();
    t_fail(2'h0, 1'b1, 1'b0);
    t_fail(2'h1, 1'b0, 1'b1);
    t_fail(2'h2, 1'b1, 1'b1);
    t_fail(2'h3, 1'b1, 1'b1);
    t_rej(2'h0, 1'b0, 1'b1);
    t_rej(2'h1, 1'b1, 1'b0);
    t_rej(2'h2, 1'b1, 1'b0);
    t_rej(2'h3, 1'b0, 1'b1);
    t_trig();
    results();
  end
endmodule // breaker_failure_supervisor_tb
